// ### design/tah_sequencer.sv
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "tah_regs.svh"
module tah_sequencer
  import tah_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // oscillator and panel front end
  input wire logic osc_clk,
  input wire logic pen_touch_raw,
  input wire logic [11:0] adc_data,
  // panel and converter control
  output logic [2:0] panel_drv,
  output logic adc_active,
  output logic busy,
  // host signalling
  output logic pen_touch_interrupt,
  output logic touch_irq_or_data_ready_pin_n,
  output logic irq
);

  tah_regs_t q;
  tah_regs_t next_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // zero-length phases still take one half cycle
  function automatic logic [15:0] atleast1(input logic [15:0] v);
    return (v == 16'h0000) ? 16'h0001 : v;
  endfunction : atleast1

  // derived configuration
  logic res12;
  logic [4:0] n_conv;
  logic [15:0] ratio;
  logic [15:0] conv_half;
  logic [15:0] ppro_half;
  logic osc_tick;
  logic phase_end;
  logic bus_req;
  logic bus_do;
  logic [2:0] res_idx;
  logic res_sel;
  logic [15:0] conv_clks;
  logic [15:0] conv_osc;
  logic [15:0] settle_half;
  logic [15:0] pre_half;
  logic [15:0] sense_half;
  logic func_wr;
  logic pen_rise;

  assign res12 = q.cfg[`TAH_CFG_RES12];
  assign n_conv = {1'b0, q.cfg[`TAH_CFG_N_LSB +: 4]} + 5'd1;
  assign ratio = atleast1({12'h000, q.cfg[`TAH_CFG_RATIO_LSB +: 4]});
  // (B+2) converter clocks per sample, stretched by the osc/adc ratio
  assign conv_clks = (res12 ? `TAH_BITS_HIGH : `TAH_BITS_LOW) + `TAH_CONV_EXTRA_CLK;
  assign conv_osc = 16'(conv_clks * ratio) + `TAH_OSC_CONV_OH;
  // counted in half cycles, since both oscillator edges tick
  assign conv_half = {conv_osc[14:0], 1'b0};
  assign ppro_half = atleast1({7'h00, q.timing[31:24], 1'b0});
  // panel phase lengths, never zero so each phase costs at least one tick
  assign settle_half = atleast1({7'h00, q.timing[7:0], 1'b0});
  assign pre_half = atleast1({7'h00, q.timing[15:8], 1'b0});
  assign sense_half = atleast1({7'h00, q.timing[23:16], 1'b0});
  // both oscillator edges count, so half-cycle overheads are exact
  assign osc_tick = (q.osc_sync[1] == q.osc_sync[2]) && (q.osc_sync[2] != q.osc);
  assign phase_end = osc_tick && (q.cnt == 16'h0001);
  // rising touch, seen once the second and third stages agree
  assign pen_rise = (q.pen_sync[1] == q.pen_sync[2]) && q.pen_sync[2] && !q.pen;
  assign bus_req = read | write;
  assign bus_do = bus_req & q.ack;
  assign func_wr = bus_do && write && (address == `TAH_OFS_FUNC) && byteenable[0];
  // result window: seven aligned words
  assign res_sel = (address >= `TAH_OFS_RES_BASE) && (address <= `TAH_OFS_RES_LAST) && (address[1:0] == 2'b00);
  assign res_idx = 3'((address - `TAH_OFS_RES_BASE) >> 2);

  always_comb begin
    logic [3:0] code;
    logic [2:0] need;
    next_q = q;
    code = writedata[3:0];
    need = 3'b000;

    // pin synchronisers: change accepted once stages two and three agree
    next_q.pen_sync = {q.pen_sync[1:0], pen_touch_raw};
    next_q.osc_sync = {q.osc_sync[1:0], osc_clk};
    if (q.pen_sync[1] == q.pen_sync[2]) begin
      next_q.pen = q.pen_sync[2];
    end
    if (q.osc_sync[1] == q.osc_sync[2]) begin
      next_q.osc = q.osc_sync[2];
    end

    // avalon: one wait cycle, read data captured in the first cycle
    next_q.ack = bus_req & ~q.ack;
    if (bus_req && !q.ack) begin
      next_q.rdata = 32'h0000_0000;
      if (read) begin
        case (address)
          `TAH_OFS_FUNC: next_q.rdata = {27'h000_0000, q.cont, q.func};
          `TAH_OFS_DRV: next_q.rdata = {29'h0000_0000, q.drv};
          `TAH_OFS_CFG: next_q.rdata = {22'h00_0000, q.cfg[9:0]};
          `TAH_OFS_TIME: next_q.rdata = q.timing;
          `TAH_OFS_STATUS: next_q.rdata = {28'h000_0000, q.ready_flag, q.state != ST_IDLE, q.status};
          `TAH_OFS_ENABLE: next_q.rdata = {30'h0000_0000, q.enable};
          default: begin
            // unmapped or misaligned addresses read zero
            if (res_sel && res_idx != 3'd7) begin
              next_q.rdata = {20'h0_0000, q.results[res_idx]};
            end
          end
        endcase
      end
    end

    // writes land at the edge where waitrequest is low
    if (bus_do && write) begin
      case (address)
        `TAH_OFS_DRV: next_q.drv = 3'(merge({29'h0000_0000, q.drv}, writedata, byteenable));
        `TAH_OFS_CFG: next_q.cfg = merge(q.cfg, writedata, byteenable) & 32'h0000_03FF;
        `TAH_OFS_TIME: next_q.timing = merge(q.timing, writedata, byteenable);
        `TAH_OFS_CLEAR: begin
          if (byteenable[0]) begin
            next_q.status = q.status & ~writedata[1:0];
          end
        end
        `TAH_OFS_ENABLE: begin
          if (byteenable[0]) begin
            next_q.enable = writedata[1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (bus_do && read && res_sel) begin
      next_q.ready_flag = 1'b0;
    end
    // event after the clear so a touch in the clearing cycle is not lost
    if (pen_rise) begin
      next_q.status[`TAH_ST_PEN] = 1'b1;
    end

    // sequencer phase counter
    if (osc_tick && q.cnt != 16'h0000) begin
      next_q.cnt = q.cnt - 16'h0001;
    end

    case (q.state)
      ST_IDLE: begin
        // a command only runs when written; nothing advances on its own
        if (func_wr) begin
          next_q.func = code;
          next_q.z_second = 1'b0;
          next_q.conv_left = n_conv;
          next_q.long_path = 1'b0;
          next_q.cont = 1'b0;
          next_q.aux_path = 1'b1;
          case (code)
            `TAH_FN_X: need = 3'b001;
            `TAH_FN_Y: need = 3'b010;
            `TAH_FN_Z: need = 3'b100;
            default: need = 3'b000;
          endcase
          case (code)
            `TAH_FN_X, `TAH_FN_Y, `TAH_FN_Z: begin
              next_q.aux_path = 1'b0;
              case (code)
                `TAH_FN_X: next_q.dst = `TAH_RES_X;
                `TAH_FN_Y: next_q.dst = `TAH_RES_Y;
                default: next_q.dst = `TAH_RES_Z1;
              endcase
              next_q.state = ST_START;
              // bits stay on afterwards; software turns them off
              if ((q.drv & need) != need) begin
                next_q.drv = q.drv | need;
                next_q.long_path = 1'b1;
                next_q.cnt = `TAH_HALF_START_LONG;
              end else begin
                next_q.cnt = `TAH_HALF_START_SHORT;
              end
            end
            `TAH_FN_AUX_SINGLE, `TAH_FN_AUX_CONT: begin
              next_q.cont = (code == `TAH_FN_AUX_CONT);
              next_q.dst = `TAH_RES_AUX;
              next_q.state = ST_START;
              next_q.cnt = `TAH_HALF_AUX_START;
            end
            `TAH_FN_TEMP_FIRST, `TAH_FN_TEMP_SECOND: begin
              // same path as single aux
              next_q.dst = (code == `TAH_FN_TEMP_FIRST) ? `TAH_RES_TEMPERATURE_MEASURE_FIRST : `TAH_RES_TEMPERATURE_MEASURE_SECOND;
              next_q.state = ST_START;
              next_q.cnt = `TAH_HALF_AUX_START;
            end
            default: begin
              // unknown codes leave the sequencer idle
            end
          endcase
        end
      end
      ST_START: begin
        if (phase_end) begin
          // aux and temperature skip every panel phase
          if (q.aux_path) begin
            next_q.state = ST_CONV;
            next_q.cnt = conv_half;
          end else if (q.long_path) begin
            next_q.state = ST_SETTLE;
            next_q.cnt = settle_half;
          end else begin
            next_q.state = ST_PRE;
            next_q.cnt = pre_half;
          end
        end
      end
      ST_SETTLE: begin
        if (phase_end) begin
          next_q.state = ST_PRE;
          next_q.cnt = pre_half;
        end
      end
      ST_PRE: begin
        if (phase_end) begin
          next_q.state = ST_SENSE;
          next_q.cnt = sense_half;
        end
      end
      ST_SENSE: begin
        if (phase_end) begin
          next_q.state = ST_PHASE_OH;
          next_q.cnt = q.long_path ? `TAH_HALF_SETTLE_OH : `TAH_HALF_PRE_SNS_OH;
        end
      end
      ST_PHASE_OH: begin
        if (phase_end) begin
          next_q.state = ST_CONV;
          next_q.cnt = conv_half;
        end
      end
      ST_CONV: begin
        if (phase_end) begin
          // filter left out: the last of the N samples is kept
          // adc lines are only valid while adc_active is high
          next_q.sample = adc_data;
          next_q.conv_left = q.conv_left - 5'd1;
          if (q.conv_left == 5'd1) begin
            next_q.state = ST_PREPROC;
            next_q.cnt = ppro_half;
          end else begin
            next_q.cnt = conv_half;
          end
        end
      end
      ST_PREPROC: begin
        if (phase_end) begin
          next_q.results[q.dst] = q.sample;
          next_q.ready_flag = 1'b1;
          next_q.status[`TAH_ST_DONE] = 1'b1;
          next_q.conv_left = n_conv;
          if (q.func == `TAH_FN_Z && !q.z_second) begin
            // second pressure reading shares the panel phases already done
            next_q.z_second = 1'b1;
            next_q.dst = `TAH_RES_Z2;
            next_q.state = ST_CONV;
            next_q.cnt = conv_half;
          end else if (q.cont) begin
            next_q.state = ST_START;
            next_q.cnt = `TAH_HALF_AUX_START;
          end else begin
            next_q.state = ST_IDLE;
          end
        end
      end
      default: begin
        next_q.state = ST_IDLE;
      end
    endcase

    // a function write stops a continuous run; others are refused while busy
    if (q.cont && q.state != ST_IDLE && func_wr) begin
      next_q.cont = 1'b0;
      next_q.state = ST_IDLE;
    end
  end

  // a reset mid-measurement drops the run and every stored result
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.state <= ST_IDLE;
      q.cfg <= `TAH_CFG_RESET;
      q.timing <= `TAH_TIME_RESET;
    end else begin
      q <= next_q;
    end
  end

  // busy and adc_active decode state; waitrequest is the bus request gated by ack; data outputs come straight from registers
  assign readdata = q.rdata;
  assign waitrequest = bus_req & ~q.ack;
  assign panel_drv = q.drv;
  assign adc_active = (q.state == ST_CONV);
  assign busy = (q.state != ST_IDLE);
  assign pen_touch_interrupt = q.pen;
  assign touch_irq_or_data_ready_pin_n = q.cfg[`TAH_CFG_PIN_DATA_READY] ? ~q.ready_flag : ~q.pen;
  assign irq = |(q.status & q.enable);

endmodule : tah_sequencer

// ### shared/tah_pkg.sv
package tah_pkg;

  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_START = 8'b0000_0010,
    ST_SETTLE = 8'b0000_0100,
    ST_PRE = 8'b0000_1000,
    ST_SENSE = 8'b0001_0000,
    ST_PHASE_OH = 8'b0010_0000,
    ST_CONV = 8'b0100_0000,
    ST_PREPROC = 8'b1000_0000
  } tah_state_t;

  typedef struct packed {
    tah_state_t state;
    logic [15:0] cnt;
    logic [4:0] conv_left;
    logic long_path;
    logic aux_path;
    logic z_second;
    logic cont;
    logic [2:0] dst;
    logic [3:0] func;
    logic [2:0] drv;
    logic [31:0] cfg;
    logic [31:0] timing;
    logic [1:0] status;
    logic [1:0] enable;
    logic ready_flag;
    logic [6:0][11:0] results;
    logic [11:0] sample;
    logic ack;
    logic [31:0] rdata;
    logic [2:0] pen_sync;
    logic pen;
    logic [2:0] osc_sync;
    logic osc;
  } tah_regs_t;

endpackage : tah_pkg

// ### shared/tah_regs.svh
`ifndef TAH_REGS_SVH
`define TAH_REGS_SVH

// register byte offsets
`define TAH_OFS_FUNC 8'h00
`define TAH_OFS_DRV 8'h04
`define TAH_OFS_CFG 8'h08
`define TAH_OFS_TIME 8'h0C
`define TAH_OFS_STATUS 8'h10
`define TAH_OFS_CLEAR 8'h14
`define TAH_OFS_ENABLE 8'h18
`define TAH_OFS_RES_BASE 8'h20
`define TAH_OFS_RES_LAST 8'h38

// converter function codes
`define TAH_FN_X 4'h2
`define TAH_FN_Y 4'h3
`define TAH_FN_Z 4'h4
`define TAH_FN_AUX_SINGLE 4'h5
`define TAH_FN_TEMP_FIRST 4'h6
`define TAH_FN_TEMP_SECOND 4'h7
`define TAH_FN_AUX_CONT 4'h8

// result slots
`define TAH_RES_X 3'd0
`define TAH_RES_Y 3'd1
`define TAH_RES_Z1 3'd2
`define TAH_RES_Z2 3'd3
`define TAH_RES_AUX 3'd4
`define TAH_RES_TEMPERATURE_MEASURE_FIRST 3'd5
`define TAH_RES_TEMPERATURE_MEASURE_SECOND 3'd6

// field positions
`define TAH_CFG_PIN_DATA_READY 0
`define TAH_CFG_RES12 1
`define TAH_CFG_N_LSB 2
`define TAH_CFG_RATIO_LSB 6
`define TAH_ST_PEN 0
`define TAH_ST_DONE 1

// reset values
`define TAH_CFG_RESET 32'h0000_0042
`define TAH_TIME_RESET 32'h0202_0204

// overheads in oscillator half cycles (figures x2); TAH_OSC_CONV_OH in cycles, TAH_CONV_EXTRA_CLK in converter clocks
`define TAH_HALF_START_SHORT 16'h0005
`define TAH_HALF_START_LONG 16'h0007
`define TAH_HALF_AUX_START 16'h0007
`define TAH_HALF_SETTLE_OH 16'h0014
`define TAH_HALF_PRE_SNS_OH 16'h000C
`define TAH_OSC_CONV_OH 16'h0003
`define TAH_CONV_EXTRA_CLK 16'h0002

// converter bits per sample
`define TAH_BITS_HIGH 16'h000C
`define TAH_BITS_LOW 16'h000A

`endif

// ### tb/tah_front_model.sv
`timescale 1ns/1ps
module tah_front_model (
  // converter side
  input wire logic adc_active,
  input wire logic [11:0] level,
  output logic [11:0] adc_data,
  // oscillator
  output logic osc_clk
);
  // free-running oscillator, phase unrelated to the system clock
  initial begin
    osc_clk = 1'b0;
    #13;
    forever #200 osc_clk = ~osc_clk;
  end

  // outside a conversion the lines carry junk, never the last result
  assign adc_data = adc_active ? level : ~level;
endmodule : tah_front_model

// ### tb/tah_sequencer_chk.sv
`timescale 1ns/1ps
`include "tah_regs.svh"
module tah_sequencer_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic [7:0] address,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  // panel and status
  input wire logic pen_touch_raw,
  input wire logic [2:0] panel_drv,
  input wire logic adc_active,
  input wire logic busy,
  input wire logic pen_touch_interrupt,
  input wire logic irq
);
  logic [8:0] gap;
  logic [8:0] conv_len;
  logic conv_seen;
  logic func_go;

  assign func_go = write && !waitrequest && address == `TAH_OFS_FUNC && byteenable[0] && !busy;

  // saturating counts; only lower bounds are checked, so the cap is harmless
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap <= 9'h0;
      conv_len <= 9'h0;
      conv_seen <= 1'b0;
    end else begin
      gap <= !busy ? 9'h0 : (gap == 9'h1FF ? gap : gap + 9'h1);
      conv_len <= !adc_active ? 9'h0 : (conv_len == 9'h1FF ? conv_len : conv_len + 9'h1);
      conv_seen <= busy && (conv_seen || adc_active);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_pen_raise: assert property (pen_touch_raw [*5] |-> pen_touch_interrupt)
    else $error("touch not flagged");
  a_pen_drop: assert property (!pen_touch_raw [*5] |-> !pen_touch_interrupt)
    else $error("touch flag stuck");
  a_drv_auto_on: assert property (func_go && writedata[3:0] == `TAH_FN_Y |-> ##[1:3] panel_drv[1])
    else $error("y drivers not switched on");
  a_busy_start: assert property (func_go && writedata[3:0] inside {[`TAH_FN_X:`TAH_FN_AUX_CONT]} |-> ##[1:3] busy)
    else $error("measurement not started");
  a_conv_inside: assert property (adc_active |-> busy)
    else $error("conversion outside measurement");
  a_conv_len: assert property ($fell(adc_active) && !$past(write) |-> conv_len >= 9'd100)
    else $error("conversion too short");
  a_start_gap: assert property ($rose(adc_active) && !conv_seen |-> gap >= 9'd20)
    else $error("start overhead missing");
  a_preproc_tail: assert property ($fell(adc_active) && !$past(write) |-> busy [*3])
    else $error("preprocessing phase missing");
  a_no_self_start: assert property ($rose(busy) |-> $past(write))
    else $error("measurement started without command");
  a_drv_cause: assert property (!$stable(panel_drv) |-> $past(write) || $past(write, 2))
    else $error("drivers changed without command");

  c_done: cover property ($fell(busy));
  c_irq: cover property ($rose(irq));
  c_touch: cover property ($rose(pen_touch_interrupt));
endmodule : tah_sequencer_chk

bind tah_sequencer tah_sequencer_chk u_chk (
  .clk(clk), .rst(rst), .address(address), .write(write), .writedata(writedata), .byteenable(byteenable),
  .waitrequest(waitrequest), .pen_touch_raw(pen_touch_raw), .panel_drv(panel_drv), .adc_active(adc_active),
  .busy(busy), .pen_touch_interrupt(pen_touch_interrupt), .irq(irq)
);

// ### tb/test_touch_adc_host_sequencer.sv
`timescale 1ns/1ps
`include "tah_regs.svh"
module test_touch_adc_host_sequencer;
  logic clk, rst, read, write, pen_touch_raw, waitrequest, adc_active, busy, pen_flag, pin_n, irq, osc_clk;
  logic [7:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic [11:0] adc_data, level;
  logic [2:0] panel_drv;
  int err_count, n_compared, cyc;

  tah_sequencer uut (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .osc_clk(osc_clk),
    .pen_touch_raw(pen_touch_raw), .adc_data(adc_data), .panel_drv(panel_drv), .adc_active(adc_active),
    .busy(busy), .pen_touch_interrupt(pen_flag), .touch_irq_or_data_ready_pin_n(pin_n), .irq(irq)
  );
  tah_front_model front (.adc_active(adc_active), .level(level), .adc_data(adc_data), .osc_clk(osc_clk));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // waitrequest and read data are looked at mid-cycle, settled for the coming edge;
  // one edge passes after release so back-to-back calls never retouch a strobe
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic stall;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    stall = 1'b1;
    while (stall) begin
      @(negedge clk);
      stall = (waitrequest !== 1'b0);
      rd = readdata;
      @(posedge clk);
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk

  // duration in oscillator half cycles, 4 clk each; slack covers edge sync
  task automatic run(input logic [3:0] code, input logic [2:0] drv, input logic [31:0] cfg, input int half,
                     input logic [7:0] slot);
    int c;
    level <= level + 12'h111;
    bus(1'b1, `TAH_OFS_CFG, cfg);
    bus(1'b1, `TAH_OFS_DRV, {29'h0, drv});
    bus(1'b1, `TAH_OFS_FUNC, {28'h0, code});
    c = 0;
    // busy is looked at mid-cycle, clear of the edge that drops it
    do begin
      @(negedge clk);
      c++;
    end while (busy === 1'b1);
    chk(32'(c >= half * 4 - 8 && c <= half * 4 + 8), 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    chk(32'(pin_n), 32'(!cfg[0]));
    rchk(slot, {20'h0, level});
    repeat (2) @(posedge clk);
    chk(32'(pin_n), 32'h1);
    bus(1'b1, `TAH_OFS_CLEAR, 32'h2);
  endtask : run

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h0;
    writedata = 32'h0;
    byteenable = 4'hF;
    pen_touch_raw = 1'b0;
    level = 12'h123;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(`TAH_OFS_CFG, `TAH_CFG_RESET);
    rchk(`TAH_OFS_TIME, `TAH_TIME_RESET);
    bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rchk(8'h3C, 32'h0);
    // touch arrives while masked, so the enable is what raises the line
    pen_touch_raw <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(pen_flag), 32'h1);
    chk(32'(pin_n), 32'h0);
    chk(32'(irq), 32'h0);
    rchk(`TAH_OFS_STATUS, 32'h1);
    bus(1'b1, `TAH_OFS_ENABLE, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    bus(1'b1, `TAH_OFS_CLEAR, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    pen_touch_raw <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(pin_n), 32'h1);
    bus(1'b1, `TAH_OFS_ENABLE, 32'h2);
    run(`TAH_FN_X, 3'h1, `TAH_CFG_RESET, 63, `TAH_OFS_RES_BASE);
    run(`TAH_FN_Y, 3'h0, `TAH_CFG_RESET, 81, `TAH_OFS_RES_BASE + 8'h4);
    chk(32'(panel_drv), 32'h2);
    run(`TAH_FN_Z, 3'h4, `TAH_CFG_RESET, 101, `TAH_OFS_RES_BASE + 8'h8);
    rchk(`TAH_OFS_RES_BASE + 8'hC, {20'h0, level});
    run(`TAH_FN_AUX_SINGLE, 3'h0, `TAH_CFG_RESET, 45, `TAH_OFS_RES_BASE + 8'h10);
    run(`TAH_FN_TEMP_FIRST, 3'h0, `TAH_CFG_RESET, 45, `TAH_OFS_RES_BASE + 8'h14);
    run(`TAH_FN_TEMP_SECOND, 3'h0, `TAH_CFG_RESET, 45, `TAH_OFS_RES_BASE + 8'h18);
    run(`TAH_FN_AUX_SINGLE, 3'h0, 32'h45, 71, `TAH_OFS_RES_BASE + 8'h10);
    level <= 12'h5C3;
    bus(1'b1, `TAH_OFS_FUNC, {28'h0, `TAH_FN_AUX_CONT});
    repeat (700) @(posedge clk);
    chk(32'(busy), 32'h1);
    bus(1'b1, `TAH_OFS_FUNC, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(busy), 32'h0);
    rchk(`TAH_OFS_RES_BASE + 8'h10, 32'h5C3);
    report_and_stop();
  end
endmodule : test_touch_adc_host_sequencer
